/* File: rtl/vem_consts.svh */
// Purpose: Constants for the video error and integrity flag monitor
// Assumes: 32-bit AXI4-Lite, register byte address is four times its index
// Notes: Definitions only
`ifndef VEM_CONSTS_SVH
`define VEM_CONSTS_SVH

`define VEM_AW 10
`define VEM_IDX_STAT_PRI 8'h02
`define VEM_IDX_STAT_SEC 8'h03
`define VEM_IDX_MASK_PRI 8'h37
`define VEM_IDX_MASK_SEC 8'h38
`define VEM_IDX_CTRL 8'h40
`define VEM_IDX_FLAGS_RX 8'h41
`define VEM_IDX_FLAGS_UPD 8'h42
`define VEM_IDX_EDH_STAT 8'h43

`define VEM_B_SAV 0
`define VEM_B_EAV 1
`define VEM_B_YCRC 2
`define VEM_B_CCRC 3
`define VEM_B_LNUM 4
`define VEM_B_APCRC 5
`define VEM_B_FFCRC 6

`define VEM_C_UPD_EN 0
`define VEM_C_CRC_INS_DIS 1
`define VEM_E_PRESENT 0
`define VEM_E_PIC_VALID 1
`define VEM_E_FIELD_VALID 2

`define VEM_MASK_RST 16'h0000
`define VEM_UPD_RST 15'h4210
`define VEM_CTRL_RST 2'h0
`define VEM_RESP_OKAY 2'h0
`define VEM_RESP_SLVERR 2'h2

`endif

/* File: rtl/vem_pkg.sv */
// Purpose: Types for the video error and integrity flag monitor
// Assumes: Constants come from vem_consts.svh
// Notes: One flag group per region, five bits each
package vem_pkg;

    typedef struct packed {
        logic unsupported_flag;
        logic ida;
        logic idh;
        logic eda;
        logic edh;
    } vem_grp_t;

    typedef struct packed {
        vem_grp_t ap;
        vem_grp_t ff;
        vem_grp_t anc;
    } vem_flags_t;

    // One decoded integrity packet, valid for one cycle
    typedef struct packed {
        logic valid;
        logic checksum_ok;
        vem_flags_t flags;
        logic pic_crc_valid;
        logic field_crc_valid;
        logic pic_crc_mismatch;
        logic field_crc_mismatch;
    } vem_edh_pkt_t;

    // Per data stream timing, line CRC and line number results
    typedef struct packed {
        logic trs_strobe;
        logic trs_is_sav;
        logic trs_phase_shift;
        logic switching_line;
        logic [9:0] trs_xyz;
        logic crc_strobe;
        logic crc_present;
        logic [17:0] crc_calc_y;
        logic [17:0] crc_rx_y;
        logic [17:0] crc_calc_c;
        logic [17:0] crc_rx_c;
        logic ln_strobe;
        logic [10:0] ln_calc;
        logic [10:0] ln_rx;
    } vem_stream_t;

    typedef struct packed {
        logic sd;
        logic hd;
        logic g3;
        logic level_b;
    } vem_mode_t;

endpackage : vem_pkg

/* File: rtl/vem_monitor.sv */
// Purpose: Video error status, error mask and integrity packet flag handling
// Assumes: Video pipeline inputs share SYS_CLK; bypass and lock are pins
// Notes: Secondary status and mask serve data stream 2 in Level B only
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "vem_consts.svh"

// Summary of operation
// - Store anc, picture and field flags of each packet taken outside bypass as received flags.
// - With update enabled, apply update rules and keep result for outgoing packet.
// - One flag set for both fields; later packet overwrites earlier.
// - No packets: unsupported bits set, packet present low, regardless of update.
// - Report picture and field CRC validity; both read zero while packet absent.
// - Flags hold until next packet; cleared at blanking end without packet.
// - Error detection runs only while processing_bypass_n is high.
// - Each error type owns one status bit, set on detection.
// - Masks reset to zero; a high mask bit stops that error's report.
// - Indicator idles high, low when any unmasked status bit is high.
// - Status and indicator clear at next field start or status read.
// - Status clears on lock loss, bypass, standard change or reset.
// - Level B keeps separate status and mask for stream two.
// - Timing marker phase shift off switching lines or bad protection bits flag start/end errors.
// - Marker checks on Y/stream one, both links in Level B, 8 and 10 bit.
// - HD and 3G line CRC mismatches set luma or chroma errors.
// - Missing line CRC also errors; none outside HD and 3G.
// - SD picture and field CRC errors are OR of both fields.
// - Packet CRC errors only in SD after correctly received packets.
// - HD and 3G line number mismatch sets line number error.
// - Packet present rises on packet, falls at blanking end without one.
module vem_monitor (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic PROCESSING_BYPASS_N,
    input wire logic PLL_LOCK_FLAG,
    input wire vem_pkg::vem_mode_t MODE,
    input wire logic STD_CHANGE,
    input wire logic FIELD_START,
    input wire logic VBLANK,
    input wire vem_pkg::vem_edh_pkt_t EDH_PKT,
    input wire vem_pkg::vem_stream_t [1:0] STREAM,
    output logic ERROR_INDICATOR_N,
    output logic INTEGRITY_PACKET_PRESENT,
    output vem_pkg::vem_flags_t UPDATED_FLAGS,
    output logic CRC_INSERT_DISABLE,
    input wire logic [`VEM_AW-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [`VEM_AW-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);

    logic [2:0] byp_sync_q;
    logic [2:0] lock_sync_q;
    logic proc_active_q;
    logic lock_q;
    logic [15:0] stat_q [2];
    logic [15:0] stat_d [2];
    logic [15:0] set_v [2];
    logic [15:0] mask_q [2];
    logic [15:0] mask_d [2];
    logic [1:0] rd_clr;
    logic clr_all;
    logic ind_q;
    logic [1:0] ctrl_q;
    vem_pkg::vem_flags_t rx_flags_q;
    vem_pkg::vem_flags_t upd_flags_q;
    vem_pkg::vem_flags_t upd_calc;
    vem_pkg::vem_flags_t ues_only;
    logic present_q;
    logic seen_q;
    logic pic_valid_q;
    logic field_valid_q;
    logic vblank_q;
    logic v_fall;
    logic pkt_take;
    logic awready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic arready_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;
    logic wr_take;
    logic rd_take;
    logic [7:0] wr_idx;
    logic [7:0] rd_idx;

    // Pins settle once the second and third stages agree
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            byp_sync_q <= 3'h0;
            lock_sync_q <= 3'h0;
            proc_active_q <= 1'b0;
            lock_q <= 1'b0;
        end else begin
            byp_sync_q <= {byp_sync_q[1:0], PROCESSING_BYPASS_N};
            lock_sync_q <= {lock_sync_q[1:0], PLL_LOCK_FLAG};
            if (byp_sync_q[1] == byp_sync_q[2]) begin
                proc_active_q <= byp_sync_q[2];
            end
            if (lock_sync_q[1] == lock_sync_q[2]) begin
                lock_q <= lock_sync_q[2];
            end
        end
    end

    // Timing marker protection bits of the xyz word, upper eight bits
    function automatic logic ham_bad(input logic [9:0] xyz);
        logic f;
        logic v;
        logic h;
        f = xyz[8];
        v = xyz[7];
        h = xyz[6];
        ham_bad = !xyz[9] || (xyz[5:2] != {v ^ h, f ^ h, f ^ v, f ^ v ^ h});
    endfunction : ham_bad

    // Per stream error detection
    for (genvar i = 0; i < 2; i++) begin : g_stream
        logic en;
        logic trs_err;
        logic line_mode;
        assign line_mode = MODE.hd || MODE.g3;
        assign en = proc_active_q && ((i == 0) || MODE.level_b);
        assign trs_err = STREAM[i].trs_strobe &&
            ((STREAM[i].trs_phase_shift && !STREAM[i].switching_line) || ham_bad(STREAM[i].trs_xyz));
        always_comb begin
            set_v[i] = 16'h0000;
            set_v[i][`VEM_B_SAV] = en && trs_err && STREAM[i].trs_is_sav;
            set_v[i][`VEM_B_EAV] = en && trs_err && !STREAM[i].trs_is_sav;
            set_v[i][`VEM_B_YCRC] = en && line_mode && STREAM[i].crc_strobe &&
                (!STREAM[i].crc_present || STREAM[i].crc_calc_y != STREAM[i].crc_rx_y);
            set_v[i][`VEM_B_CCRC] = en && line_mode && STREAM[i].crc_strobe &&
                (!STREAM[i].crc_present || STREAM[i].crc_calc_c != STREAM[i].crc_rx_c);
            set_v[i][`VEM_B_LNUM] = en && line_mode && STREAM[i].ln_strobe &&
                (STREAM[i].ln_calc != STREAM[i].ln_rx);
            if (i == 0) begin
                set_v[i][`VEM_B_APCRC] = en && MODE.sd && EDH_PKT.valid && EDH_PKT.checksum_ok &&
                    EDH_PKT.pic_crc_mismatch;
                set_v[i][`VEM_B_FFCRC] = en && MODE.sd && EDH_PKT.valid && EDH_PKT.checksum_ok &&
                    EDH_PKT.field_crc_mismatch;
            end
        end
    end

    assign clr_all = !lock_q || !proc_active_q || STD_CHANGE || FIELD_START;

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            // Set wins over any clear in the same cycle
            if (clr_all || rd_clr[i] || (i == 1 && !MODE.level_b)) begin
                stat_d[i] = set_v[i];
            end else begin
                stat_d[i] = stat_q[i] | set_v[i];
            end
            mask_d[i] = mask_q[i];
        end
        if (wr_take && wr_idx == `VEM_IDX_MASK_PRI) begin
            if (S_AXI_WSTRB[0]) mask_d[0][7:0] = S_AXI_WDATA[7:0];
            if (S_AXI_WSTRB[1]) mask_d[0][15:8] = S_AXI_WDATA[15:8];
        end
        if (wr_take && wr_idx == `VEM_IDX_MASK_SEC) begin
            if (S_AXI_WSTRB[0]) mask_d[1][7:0] = S_AXI_WDATA[7:0];
            if (S_AXI_WSTRB[1]) mask_d[1][15:8] = S_AXI_WDATA[15:8];
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            stat_q[0] <= 16'h0000;
            stat_q[1] <= 16'h0000;
            mask_q[0] <= `VEM_MASK_RST;
            mask_q[1] <= `VEM_MASK_RST;
            ind_q <= 1'b1;
        end else begin
            stat_q[0] <= stat_d[0];
            stat_q[1] <= stat_d[1];
            mask_q[0] <= mask_d[0];
            mask_q[1] <= mask_d[1];
            ind_q <= ~|((stat_d[0] & ~mask_d[0]) | (stat_d[1] & ~mask_d[1]));
        end
    end

    // Update of flags for the outgoing packet
    function automatic vem_pkg::vem_grp_t grp_upd(input vem_pkg::vem_grp_t g, input logic local_err);
        vem_pkg::vem_grp_t r;
        r.edh = local_err;
        r.eda = g.eda || g.edh;
        r.idh = 1'b0;
        r.ida = g.ida || g.idh;
        r.unsupported_flag = g.unsupported_flag;
        grp_upd = r;
    endfunction : grp_upd

    always_comb begin
        upd_calc.anc = grp_upd(EDH_PKT.flags.anc, 1'b0);
        upd_calc.ff = grp_upd(EDH_PKT.flags.ff, EDH_PKT.field_crc_mismatch);
        upd_calc.ap = grp_upd(EDH_PKT.flags.ap, EDH_PKT.pic_crc_mismatch);
        ues_only = '0;
        ues_only.anc.unsupported_flag = 1'b1;
        ues_only.ff.unsupported_flag = 1'b1;
        ues_only.ap.unsupported_flag = 1'b1;
    end

    assign pkt_take = EDH_PKT.valid && proc_active_q;
    assign v_fall = vblank_q && !VBLANK;

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            vblank_q <= 1'b0;
            seen_q <= 1'b0;
            present_q <= 1'b0;
            rx_flags_q <= '0;
            upd_flags_q <= vem_pkg::vem_flags_t'(`VEM_UPD_RST);
            pic_valid_q <= 1'b0;
            field_valid_q <= 1'b0;
        end else begin
            vblank_q <= VBLANK;
            if (v_fall) begin
                seen_q <= pkt_take;
            end else if (pkt_take) begin
                seen_q <= 1'b1;
            end
            if (pkt_take) begin
                rx_flags_q <= EDH_PKT.flags;
                upd_flags_q <= ctrl_q[`VEM_C_UPD_EN] ? upd_calc : EDH_PKT.flags;
                present_q <= 1'b1;
                pic_valid_q <= EDH_PKT.pic_crc_valid;
                field_valid_q <= EDH_PKT.field_crc_valid;
            end else if (v_fall && !seen_q) begin
                rx_flags_q <= '0;
                upd_flags_q <= ues_only;
                present_q <= 1'b0;
                pic_valid_q <= 1'b0;
                field_valid_q <= 1'b0;
            end
        end
    end

    // Register bus slave
    assign wr_idx = S_AXI_AWADDR[`VEM_AW-1:2];
    assign rd_idx = S_AXI_ARADDR[`VEM_AW-1:2];
    assign wr_take = awready_q && S_AXI_AWVALID && S_AXI_WVALID;
    assign rd_take = arready_q && S_AXI_ARVALID;
    assign rd_clr[0] = rd_take && rd_idx == `VEM_IDX_STAT_PRI;
    assign rd_clr[1] = rd_take && rd_idx == `VEM_IDX_STAT_SEC;

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            awready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= `VEM_RESP_OKAY;
            ctrl_q <= `VEM_CTRL_RST;
        end else begin
            awready_q <= S_AXI_AWVALID && S_AXI_WVALID && !awready_q && !bvalid_q;
            if (wr_take) begin
                bvalid_q <= 1'b1;
                bresp_q <= `VEM_RESP_OKAY;
                if (wr_idx == `VEM_IDX_CTRL) begin
                    if (S_AXI_WSTRB[0]) ctrl_q <= S_AXI_WDATA[1:0];
                end else if (wr_idx != `VEM_IDX_MASK_PRI && wr_idx != `VEM_IDX_MASK_SEC &&
                             wr_idx != `VEM_IDX_STAT_PRI && wr_idx != `VEM_IDX_STAT_SEC &&
                             wr_idx != `VEM_IDX_FLAGS_RX && wr_idx != `VEM_IDX_FLAGS_UPD &&
                             wr_idx != `VEM_IDX_EDH_STAT) begin
                    bresp_q <= `VEM_RESP_SLVERR;
                end
            end else if (S_AXI_BREADY) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rresp_q <= `VEM_RESP_OKAY;
            rdata_q <= 32'h00000000;
        end else begin
            arready_q <= S_AXI_ARVALID && !arready_q && !rvalid_q;
            if (rd_take) begin
                rvalid_q <= 1'b1;
                rresp_q <= `VEM_RESP_OKAY;
                rdata_q <= 32'h00000000;
                case (rd_idx)
                    `VEM_IDX_STAT_PRI: rdata_q[15:0] <= stat_q[0];
                    `VEM_IDX_STAT_SEC: rdata_q[15:0] <= stat_q[1];
                    `VEM_IDX_MASK_PRI: rdata_q[15:0] <= mask_q[0];
                    `VEM_IDX_MASK_SEC: rdata_q[15:0] <= mask_q[1];
                    `VEM_IDX_CTRL: rdata_q[1:0] <= ctrl_q;
                    `VEM_IDX_FLAGS_RX: rdata_q[14:0] <= rx_flags_q;
                    `VEM_IDX_FLAGS_UPD: rdata_q[14:0] <= upd_flags_q;
                    `VEM_IDX_EDH_STAT: begin
                        rdata_q[`VEM_E_PRESENT] <= present_q;
                        rdata_q[`VEM_E_PIC_VALID] <= pic_valid_q && present_q;
                        rdata_q[`VEM_E_FIELD_VALID] <= field_valid_q && present_q;
                    end
                    default: rresp_q <= `VEM_RESP_SLVERR;
                endcase
            end else if (S_AXI_RREADY) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    assign ERROR_INDICATOR_N = ind_q;
    assign INTEGRITY_PACKET_PRESENT = present_q;
    assign UPDATED_FLAGS = upd_flags_q;
    assign CRC_INSERT_DISABLE = ctrl_q[`VEM_C_CRC_INS_DIS];
    assign S_AXI_AWREADY = awready_q;
    assign S_AXI_WREADY = awready_q;
    assign S_AXI_BVALID = bvalid_q;
    assign S_AXI_BRESP = bresp_q;
    assign S_AXI_ARREADY = arready_q;
    assign S_AXI_RVALID = rvalid_q;
    assign S_AXI_RRESP = rresp_q;
    assign S_AXI_RDATA = rdata_q;

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);

    sequence s_blank_end_empty;
        v_fall && !seen_q && !pkt_take;
    endsequence
    sequence s_flags_cleared;
        !present_q && rx_flags_q == '0 && upd_flags_q == ues_only;
    endsequence
    sequence s_wr_take;
        awready_q && S_AXI_AWVALID && S_AXI_WVALID;
    endsequence

    property p_ind_nor;
        ERROR_INDICATOR_N == !(|(stat_q[0] & ~mask_q[0]) || |(stat_q[1] & ~mask_q[1]));
    endproperty
    a_ind_nor: assert property (p_ind_nor) else $error("Indicator not NOR of masked status");

    property p_bypass_clear;
        !proc_active_q |=> stat_q[0] == 16'h0000 && stat_q[1] == 16'h0000;
    endproperty
    a_bypass_clear: assert property (p_bypass_clear) else $error("Status set while bypassed");

    property p_sav_set;
        proc_active_q && STREAM[0].trs_strobe && STREAM[0].trs_is_sav && ham_bad(STREAM[0].trs_xyz)
            |=> stat_q[0][`VEM_B_SAV];
    endproperty
    a_sav_set: assert property (p_sav_set) else $error("Start marker error not set");

    property p_crc_mode;
        $rose(stat_q[0][`VEM_B_YCRC]) |-> $past(MODE.hd || MODE.g3);
    endproperty
    a_crc_mode: assert property (p_crc_mode) else $error("Line CRC error outside HD or 3G");

    property p_ues_absent;
        !present_q |-> upd_flags_q.ap.unsupported_flag && upd_flags_q.ff.unsupported_flag && upd_flags_q.anc.unsupported_flag;
    endproperty
    a_ues_absent: assert property (p_ues_absent) else $error("Unsupported flags low while absent");

    property p_blank_clear;
        s_blank_end_empty |=> s_flags_cleared;
    endproperty
    a_blank_clear: assert property (p_blank_clear) else $error("Flags not cleared at blanking end");

    property p_pkt_store;
        pkt_take |=> present_q && rx_flags_q == $past(EDH_PKT.flags);
    endproperty
    a_pkt_store: assert property (p_pkt_store) else $error("Packet flags not stored");

    property p_read_clear;
        rd_clr[0] && set_v[0] == 16'h0000 |=> stat_q[0] == 16'h0000;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("Status not cleared on read");

    property p_write_resp;
        s_wr_take |=> S_AXI_BVALID && !S_AXI_AWREADY;
    endproperty
    a_write_resp: assert property (p_write_resp) else $error("Write response missing");

endmodule : vem_monitor
`default_nettype wire

/* File: bench/vem_src_model.sv */
// Purpose: Far-side video source driving packets, timing and CRC results
// Assumes: Calls start just after a rising clock edge
// Notes: Lines between strobes carry inverted junk
`timescale 1ns/10ps
`default_nettype none
module vem_src_model (
    input wire logic clk,
    output vem_pkg::vem_edh_pkt_t pkt,
    output vem_pkg::vem_stream_t [1:0] st,
    output logic vblank
);
    initial begin
        pkt = '0;
        st = '0;
        vblank = 1'b0;
    end
    task automatic drive(input int s, input vem_pkg::vem_stream_t v);
        vem_pkg::vem_stream_t j;
        j = ~v;
        j.trs_strobe = 1'b0;
        j.crc_strobe = 1'b0;
        j.ln_strobe = 1'b0;
        @(posedge clk);
        st[s] <= v;
        @(posedge clk);
        st[s] <= j;
    endtask : drive
    task automatic trs(input int s, input logic sav, input logic ph, input logic sw, input logic [9:0] xyz);
        vem_pkg::vem_stream_t v;
        v = '0;
        v.trs_strobe = 1'b1;
        v.trs_is_sav = sav;
        v.trs_phase_shift = ph;
        v.switching_line = sw;
        v.trs_xyz = xyz;
        drive(s, v);
    endtask : trs
    task automatic crc(input logic pr, input logic [17:0] cy, input logic [17:0] ry, input logic [17:0] cc);
        vem_pkg::vem_stream_t v;
        v = '0;
        v.crc_strobe = 1'b1;
        v.crc_present = pr;
        v.crc_calc_y = cy;
        v.crc_rx_y = ry;
        v.crc_calc_c = cc;
        v.crc_rx_c = 18'h00005;
        drive(0, v);
    endtask : crc
    task automatic lnum(input logic [10:0] c, input logic [10:0] r);
        vem_pkg::vem_stream_t v;
        v = '0;
        v.ln_strobe = 1'b1;
        v.ln_calc = c;
        v.ln_rx = r;
        drive(0, v);
    endtask : lnum
    task automatic send(input vem_pkg::vem_edh_pkt_t p);
        vem_pkg::vem_edh_pkt_t j;
        j = ~p;
        j.valid = 1'b0;
        @(posedge clk);
        pkt <= p;
        @(posedge clk);
        pkt <= j;
    endtask : send
    task automatic blank;
        @(posedge clk);
        vblank <= 1'b1;
        repeat (4) @(posedge clk);
        vblank <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : blank
endmodule : vem_src_model
`default_nettype wire

/* File: bench/vem_monitor_test.sv */
// Purpose: Self-checking bench for the video error monitor
// Assumes: AXI4-Lite master, byte address four times index
// Notes: One task per scenario
`timescale 1ns/10ps
`default_nettype none
module vem_monitor_test;
    logic clk, rst_n, byp_n, lock, stdc, fst, awv, wv, bready, arv, rready;
    logic awrdy, wrdy, bvalid, arrdy, rvalid, err_n, pres, insd;
    logic [9:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [1:0] bresp, rresp, r;
    vem_pkg::vem_mode_t mode;
    vem_pkg::vem_flags_t upd;
    vem_pkg::vem_edh_pkt_t pkt;
    vem_pkg::vem_stream_t [1:0] st;
    logic vblank;
    int err_total, n_compared;
    vem_src_model src (.clk(clk), .pkt(pkt), .st(st), .vblank(vblank));
    vem_monitor dut (.SYS_CLK(clk), .RST_N(rst_n), .PROCESSING_BYPASS_N(byp_n), .PLL_LOCK_FLAG(lock),
        .MODE(mode), .STD_CHANGE(stdc), .FIELD_START(fst), .VBLANK(vblank), .EDH_PKT(pkt), .STREAM(st),
        .ERROR_INDICATOR_N(err_n), .INTEGRITY_PACKET_PRESENT(pres), .UPDATED_FLAGS(upd),
        .CRC_INSERT_DISABLE(insd), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awrdy),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arrdy), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] i, input logic [31:0] v);
        int n;
        awaddr <= {i, 2'b00};
        wdata <= v;
        awv <= 1'b1;
        wv <= 1'b1;
        n = 0;
        // Ready judged mid-cycle, taken at next rising edge
        do begin @(negedge clk); n++; end while (awrdy !== 1'b1 && n < 50);
        @(posedge clk);
        awv <= 1'b0;
        wv <= 1'b0;
        bready <= 1'b1;
        do begin @(negedge clk); n++; end while (bvalid !== 1'b1 && n < 100);
        r = bresp;
        @(posedge clk);
        bready <= 1'b0;
        if (n >= 100) err_total++;
    endtask : wr
    task automatic rd(input logic [7:0] i);
        int n;
        araddr <= {i, 2'b00};
        arv <= 1'b1;
        n = 0;
        do begin @(negedge clk); n++; end while (arrdy !== 1'b1 && n < 50);
        @(posedge clk);
        arv <= 1'b0;
        rready <= 1'b1;
        do begin @(negedge clk); n++; end while (rvalid !== 1'b1 && n < 100);
        d = rdata;
        r = rresp;
        @(posedge clk);
        rready <= 1'b0;
        if (n >= 100) err_total++;
    endtask : rd
    task automatic settle;
        repeat (2) @(posedge clk);
    endtask : settle
    task automatic t_reset;
        chk(err_n, 1);
        chk(upd, 32'h4210);
        rd(8'h37);
        chk(d, 0);
        rd(8'h38);
        chk(d, 0);
        rd(8'h43);
        chk(d, 0);
        rd(8'h10);
        chk(r, 2);
        chk(d, 0);
        wr(8'h10, 32'h0000FFFF);
        chk(r, 2);
        rd(8'h37);
        chk(d, 0);
        wr(8'h40, 2);
        chk(r, 0);
        chk(insd, 1);
        wr(8'h40, 0);
        chk(insd, 0);
    endtask : t_reset
    task automatic t_trs;
        src.trs(0, 1, 0, 0, 10'h204);
        settle;
        chk(err_n, 0);
        rd(8'h02);
        chk(d, 1);
        rd(8'h02);
        chk(d, 0);
        chk(err_n, 1);
        src.trs(0, 0, 1, 0, 10'h274);
        settle;
        rd(8'h02);
        chk(d, 2);
        src.trs(0, 0, 1, 1, 10'h274);
        src.trs(0, 1, 0, 0, 10'h200);
        src.trs(1, 1, 0, 0, 10'h204);
        settle;
        rd(8'h02);
        chk(d, 0);
        rd(8'h03);
        chk(d, 0);
    endtask : t_trs
    task automatic t_mask;
        wr(8'h37, 1);
        src.trs(0, 1, 0, 0, 10'h204);
        settle;
        chk(err_n, 1);
        fst <= 1'b1;
        @(posedge clk);
        fst <= 1'b0;
        settle;
        rd(8'h02);
        chk(d, 0);
        src.trs(0, 1, 0, 0, 10'h204);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        chk(err_n, 1);
        rd(8'h37);
        chk(d, 0);
        rd(8'h02);
        chk(d, 0);
    endtask : t_mask
    task automatic t_crc;
        src.crc(1, 18'h1, 18'h2, 18'h5);
        settle;
        rd(8'h02);
        chk(d, 4);
        src.crc(1, 18'h5, 18'h5, 18'h1);
        settle;
        rd(8'h02);
        chk(d, 8);
        src.crc(0, 18'h5, 18'h5, 18'h5);
        src.lnum(11'h010, 11'h011);
        settle;
        rd(8'h02);
        chk(d, 32'h1C);
        mode <= 4'h8;
        src.crc(1, 18'h1, 18'h2, 18'h1);
        src.lnum(11'h001, 11'h002);
        settle;
        rd(8'h02);
        chk(d, 0);
    endtask : t_crc
    task automatic t_levelb;
        mode <= 4'h3;
        src.trs(1, 1, 0, 0, 10'h204);
        settle;
        rd(8'h03);
        chk(d, 1);
        src.trs(0, 0, 1, 0, 10'h274);
        lock <= 1'b0;
        repeat (8) @(posedge clk);
        lock <= 1'b1;
        repeat (8) @(posedge clk);
        rd(8'h02);
        chk(d, 0);
        src.trs(0, 0, 1, 0, 10'h274);
        stdc <= 1'b1;
        @(posedge clk);
        stdc <= 1'b0;
        settle;
        rd(8'h02);
        chk(d, 0);
        byp_n <= 1'b0;
        repeat (8) @(posedge clk);
        src.trs(0, 0, 1, 0, 10'h274);
        settle;
        chk(err_n, 1);
        byp_n <= 1'b1;
        repeat (8) @(posedge clk);
    endtask : t_levelb
    task automatic t_edh;
        mode <= 4'h8;
        wr(8'h40, 1);
        src.send({2'b10, 15'h0001, 4'b1011});
        settle;
        rd(8'h02);
        chk(d, 0);
        src.send({2'b11, 15'h1422, 4'b1010});
        settle;
        rd(8'h02);
        chk(d, 32'h20);
        rd(8'h41);
        chk(d, 32'h1422);
        rd(8'h42);
        chk(d, 32'h2C42);
        rd(8'h43);
        chk(d, 3);
        src.blank;
        chk(pres, 1);
        rd(8'h41);
        chk(d, 32'h1422);
        src.blank;
        chk(pres, 0);
        rd(8'h41);
        chk(d, 0);
        rd(8'h43);
        chk(d, 0);
        chk(upd, 32'h4210);
    endtask : t_edh
    task wrap_up;
        if (err_total == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : wrap_up
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #100000;
        err_total++;
        wrap_up;
    end
    initial begin
        {rst_n, stdc, fst, awv, wv, bready, arv, rready} = '0;
        {byp_n, lock} = 2'b11;
        mode = 4'h4;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        err_total = 0;
        n_compared = 0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        t_reset;
        t_trs;
        t_mask;
        t_crc;
        t_levelb;
        t_edh;
        wrap_up;
    end
endmodule : vem_monitor_test
`default_nettype wire
